// ===== core/msq_seq.v
/*
 Sequencer counters: MIDI clock interpolator, 8-bit recording counter,
 signed playback counter, AXI4-Lite register slave.
 Assumes the MIDI clock pulse, control messages and interrupt clears come
 from logic on the same clock, one cycle wide each.
*/
`timescale 1ns/10ps
`include "msq_regs.vh"
module msq_seq (
   input wire clock_i, // 10 MHz system clock
   input wire rst_n_i, // Async reset, active low
   input wire ce_i, // Clock enable, freezes all state when low
   input wire init_clr_i, // Software initial clear pulse
   input wire midi_clk_i, // Internal MIDI clock pulse
   input wire msg_valid_i, // Control message strobe
   input wire [7:0] msg_code_i, // Control message status byte
   input wire [1:0] msg_dst_i, // Targets: bit0 recording, bit1 playback
   input wire rec_irq_clr_i, // Recording interrupt clear pulse
   input wire play_irq_clr_i, // Playback interrupt clear pulse
   output wire rec_irq_o, // Recording wrap interrupt level
   output wire play_irq_o, // Playback interrupt level
   input wire [3:0] s_axi_awaddr, // Write address
   input wire s_axi_awvalid, // Write address valid
   output wire s_axi_awready, // Write address ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Write strobes
   input wire s_axi_wvalid, // Write data valid
   output wire s_axi_wready, // Write data ready
   output wire [1:0] s_axi_bresp, // Write response
   output wire s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire [3:0] s_axi_araddr, // Read address
   input wire s_axi_arvalid, // Read address valid
   output wire s_axi_arready, // Read address ready
   output wire [31:0] s_axi_rdata, // Read data
   output wire [1:0] s_axi_rresp, // Read response
   output wire s_axi_rvalid, // Read valid
   input wire s_axi_rready // Read ready
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Count clocks still owed in the running interval
   function [3:0] owed;
      input [3:0] rate;
      input [3:0] done;
      begin
         owed = (rate > done) ? (rate - done) : 4'h0;
      end
   endfunction

   // ----------------------------------------
   // Register file and bus state
   // ----------------------------------------
   reg [7:0] ctrl_reg;
   reg [7:0] add_lo_reg;
   reg [6:0] add_hi_reg;
   reg add_req_reg;
   reg clr_req_reg;
   reg awready_reg;
   reg wready_reg;
   reg aw_have_reg;
   reg w_have_reg;
   reg [3:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg arready_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;

   // ----------------------------------------
   // Interpolator and counter state
   // ----------------------------------------
   reg [3:0] pre_reg;
   reg [15:0] meas_reg;
   reg [15:0] per_reg;
   reg [3:0] rate_act_reg;
   reg [19:0] acc_reg;
   reg [3:0] emit_reg;
   reg [4:0] def_reg;
   reg [1:0] act_reg;
   reg [1:0] pend_reg;
   reg [3:0] bur0_reg;
   reg [3:0] bur1_reg;
   reg [7:0] rec_reg;
   reg [15:0] play_reg;
   reg rec_irq_reg;
   reg play_irq_reg;

   wire unit = (pre_reg == `MSQ_UNIT_LAST);
   wire [19:0] acc_sum = acc_reg + {16'h0000, rate_act_reg};
   wire msg_start = msg_valid_i && (msg_code_i == `MSQ_MSG_START);
   wire msg_stop = msg_valid_i && (msg_code_i == `MSQ_MSG_STOP);
   wire msg_cont = msg_valid_i && (msg_code_i == `MSQ_MSG_CONT);

   // Regular tick: on a unit edge when the accumulated share passes the
   // measured period, never beyond the rate, and held off while deferred ticks drain
   wire rtick = unit && !midi_clk_i && (def_reg == 5'h00) &&
      (emit_reg < rate_act_reg) && (acc_sum >= {4'h0, per_reg});
   wire dtick = (def_reg != 5'h00);
   wire tick = rtick || dtick;

   // Per-counter count clocks: shared ticks while running, plus stop burst
   wire rec_tick = (tick && act_reg[0]) || (bur0_reg != 4'h0);
   wire play_tick = (tick && act_reg[1]) || (bur1_reg != 4'h0);

   // ----------------------------------------
   // Interval measurement and tick spacing
   // ----------------------------------------
   // The period and rate latched at one MIDI clock pace the next interval,
   // so a tempo or rate change shows up one MIDI clock later.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_reg <= 4'h0;
         meas_reg <= 16'h0000;
         per_reg <= 16'hffff;
         rate_act_reg <= 4'h0;
         acc_reg <= 20'h00000;
         emit_reg <= 4'h0;
         def_reg <= 5'h00;
      end else if (ce_i) begin
         pre_reg <= pre_reg + 4'h1;
         if (def_reg != 5'h00) begin
            def_reg <= def_reg - 5'h01;
         end
         if (midi_clk_i) begin
            meas_reg <= 16'h0000;
            per_reg <= (meas_reg == 16'h0000) ? 16'h0001 : meas_reg;
            rate_act_reg <= ctrl_reg[`MSQ_RATE_MSB:0];
            acc_reg <= 20'h00000;
            emit_reg <= 4'h0;
            // Missing ticks of the closing interval go out back to back
            def_reg <= def_reg - {4'h0, dtick} +
               {1'b0, owed(rate_act_reg, emit_reg)};
         end else begin
            if (unit && meas_reg != 16'hffff) begin
               meas_reg <= meas_reg + 16'h0001;
            end
            if (unit) begin
               acc_reg <= rtick ? (acc_sum - {4'h0, per_reg}) : acc_sum;
            end
            if (rtick) begin
               emit_reg <= emit_reg + 4'h1;
            end
         end
         if (init_clr_i) begin
            def_reg <= 5'h00;
         end
      end
   end

   // ----------------------------------------
   // Run control of the two counters
   // ----------------------------------------
   // Start and continue only arm a counter; it joins at the next MIDI
   // clock. Stop halts at once but first pays out the ticks still due.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_reg <= 2'b00;
         pend_reg <= 2'b00;
         bur0_reg <= 4'h0;
         bur1_reg <= 4'h0;
      end else if (ce_i) begin
         if (bur0_reg != 4'h0) begin
            bur0_reg <= bur0_reg - 4'h1;
         end
         if (bur1_reg != 4'h0) begin
            bur1_reg <= bur1_reg - 4'h1;
         end
         if (midi_clk_i) begin
            act_reg <= act_reg | pend_reg;
            pend_reg <= 2'b00;
         end
         if (msg_start || msg_cont) begin
            pend_reg <= pend_reg | msg_dst_i;
            if (msg_start) begin
               act_reg <= act_reg & ~msg_dst_i;
            end
         end
         if (msg_stop) begin
            act_reg <= act_reg & ~msg_dst_i;
            pend_reg <= pend_reg & ~msg_dst_i;
            if (msg_dst_i[0] && act_reg[0]) begin
               bur0_reg <= owed(rate_act_reg, emit_reg + {3'h0, rtick});
            end
            if (msg_dst_i[1] && act_reg[1]) begin
               bur1_reg <= owed(rate_act_reg, emit_reg + {3'h0, rtick});
            end
         end
         if (init_clr_i) begin
            act_reg <= 2'b00;
            pend_reg <= 2'b00;
            bur0_reg <= 4'h0;
            bur1_reg <= 4'h0;
         end
      end
   end

   // ----------------------------------------
   // Recording counter
   // ----------------------------------------
   // The wrap flag is sticky; a wrap in the clear cycle keeps it set.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rec_reg <= 8'h00;
         rec_irq_reg <= 1'b0;
      end else if (ce_i) begin
         if (init_clr_i) begin
            rec_reg <= 8'h00;
            rec_irq_reg <= 1'b0;
         end else begin
            if (msg_start && msg_dst_i[0]) begin
               rec_reg <= 8'h00;
            end else if (rec_tick) begin
               rec_reg <= rec_reg + 8'h01;
            end
            if (rec_tick && !(msg_start && msg_dst_i[0]) && rec_reg == 8'hff) begin
               rec_irq_reg <= 1'b1;
            end else if (rec_irq_clr_i) begin
               rec_irq_reg <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Playback counter
   // ----------------------------------------
   // Zeroing (start or clear) is applied before the addend, then a count
   // clock subtracts one. Wraps silently at the 16-bit signed range.
   reg [15:0] play_next;
   always @* begin
      play_next = play_reg;
      if ((msg_start && msg_dst_i[1]) || clr_req_reg) begin
         play_next = 16'h0000;
      end
      if (add_req_reg) begin
         play_next = play_next + {1'b0, add_hi_reg, add_lo_reg};
      end
      if (play_tick) begin
         play_next = play_next - 16'h0001;
      end
   end

   wire play_le0 = play_reg[15] || (play_reg == 16'h0000);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         play_reg <= 16'h0000;
         play_irq_reg <= 1'b0;
      end else if (ce_i) begin
         if (init_clr_i) begin
            play_reg <= 16'h0000;
            play_irq_reg <= 1'b0;
         end else begin
            play_reg <= play_next;
            if (play_le0) begin
               play_irq_reg <= 1'b1;
            end else if (play_irq_clr_i) begin
               play_irq_reg <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   // Address and data are taken in either order; one write at a time.
   // Control bits b5/b4 are one-cycle requests, not stored.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `MSQ_RESP_OK;
         ctrl_reg <= `MSQ_CTRL_RST;
         add_lo_reg <= `MSQ_ADD_RST;
         add_hi_reg <= 7'h00;
         add_req_reg <= 1'b0;
         clr_req_reg <= 1'b0;
      end else if (ce_i) begin
         add_req_reg <= 1'b0;
         clr_req_reg <= 1'b0;
         awready_reg <= !aw_have_reg && !bvalid_reg && !(s_axi_awvalid && awready_reg);
         wready_reg <= !w_have_reg && !bvalid_reg && !(s_axi_wvalid && wready_reg);
         if (s_axi_awvalid && awready_reg) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_reg) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (aw_have_reg && w_have_reg && !bvalid_reg) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= `MSQ_RESP_OK;
            case ({awaddr_reg[3:2], 2'b00})
               `MSQ_OFS_REC_COUNT: begin
               end
               `MSQ_OFS_CTRL: begin
                  if (wstrb_reg[0]) begin
                     ctrl_reg <= {2'b00, 2'b00, wdata_reg[3:0]};
                     add_req_reg <= wdata_reg[`MSQ_CTRL_ADD];
                     clr_req_reg <= wdata_reg[`MSQ_CTRL_CLR];
                  end
               end
               `MSQ_OFS_ADD_LO: begin
                  if (wstrb_reg[0]) begin
                     add_lo_reg <= wdata_reg[7:0];
                  end
               end
               `MSQ_OFS_ADD_HI: begin
                  if (wstrb_reg[0]) begin
                     add_hi_reg <= wdata_reg[6:0];
                  end
               end
               default: begin
                  bresp_reg <= `MSQ_RESP_ERR;
               end
            endcase
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (init_clr_i) begin
            ctrl_reg <= `MSQ_CTRL_RST;
            add_lo_reg <= `MSQ_ADD_RST;
            add_hi_reg <= 7'h00;
            add_req_reg <= 1'b0;
            clr_req_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   // Only the recording count reads back; write-only words read zero.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `MSQ_RESP_OK;
      end else if (ce_i) begin
         arready_reg <= !rvalid_reg && !(s_axi_arvalid && arready_reg);
         if (s_axi_arvalid && arready_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `MSQ_RESP_OK;
            case ({s_axi_araddr[3:2], 2'b00})
               `MSQ_OFS_REC_COUNT: begin
                  rdata_reg <= {24'h000000, rec_reg};
               end
               `MSQ_OFS_CTRL, `MSQ_OFS_ADD_LO, `MSQ_OFS_ADD_HI: begin
               end
               default: begin
                  rresp_reg <= `MSQ_RESP_ERR;
               end
            endcase
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rec_irq_o = rec_irq_reg;
   assign play_irq_o = play_irq_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

endmodule

// ===== inc/msq_regs.vh
/*
 Register map, field positions, reset values and message codes of the
 sequencer counter block.
 Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
*/
`ifndef MSQ_REGS_VH
`define MSQ_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MSQ_OFS_REC_COUNT 4'h0
`define MSQ_OFS_CTRL 4'h4
`define MSQ_OFS_ADD_LO 4'h8
`define MSQ_OFS_ADD_HI 4'hc

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define MSQ_CTRL_ADD 5
`define MSQ_CTRL_CLR 4
`define MSQ_RATE_MSB 3
`define MSQ_CTRL_RST 8'h00
`define MSQ_ADD_RST 8'h00

// ----------------------------------------
// Messages, responses and timing
// ----------------------------------------
`define MSQ_MSG_START 8'hfa
`define MSQ_MSG_STOP 8'hfb
`define MSQ_MSG_CONT 8'hfc
`define MSQ_RESP_OK 2'h0
`define MSQ_RESP_ERR 2'h2
`define MSQ_UNIT_LAST 4'hf

`endif

// ===== dv/msq_seq_checker.sv
/*
 Concurrent checks on the sequencer counter block ports.
 Assumes one clock domain and that the bench keeps ce_i high around bus traffic.
*/
`timescale 1ns/10ps
`include "msq_regs.vh"
module msq_seq_checker (
   input wire clock_i, // System clock
   input wire rst_n_i, // Async reset, active low
   input wire ce_i, // Clock enable
   input wire init_clr_i, // Initial clear
   input wire msg_valid_i, // Message strobe
   input wire [7:0] msg_code_i, // Message byte
   input wire [1:0] msg_dst_i, // Message targets
   input wire rec_irq_clr_i, // Recording irq clear
   input wire play_irq_clr_i, // Playback irq clear
   input wire rec_irq_o, // Recording irq
   input wire play_irq_o, // Playback irq
   input wire s_axi_awvalid, // Write address valid
   input wire s_axi_awready, // Write address ready
   input wire s_axi_wvalid, // Write data valid
   input wire s_axi_wready, // Write data ready
   input wire [1:0] s_axi_bresp, // Write response
   input wire s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire s_axi_arvalid, // Read address valid
   input wire s_axi_arready, // Read address ready
   input wire [31:0] s_axi_rdata, // Read data
   input wire s_axi_rvalid, // Read valid
   input wire s_axi_rready // Read ready
);
   // ----
   // Sequences and properties
   // ----
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Start aimed at playback, then one running cycle so the count can settle
   sequence s_play_start;
      msg_valid_i && msg_code_i == `MSQ_MSG_START && msg_dst_i[1] && ce_i ##1 ce_i;
   endsequence
   sequence s_init;
      init_clr_i && ce_i ##1 ce_i;
   endsequence
   property p_wr_resp;
      s_wr_take |-> ##2 s_axi_bvalid;
   endproperty
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_aw_drop;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && s_axi_bresp == `MSQ_RESP_OK;
   endproperty
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rec_hold;
      rec_irq_o && !rec_irq_clr_i && !init_clr_i |=> rec_irq_o;
   endproperty
   property p_play_hold;
      play_irq_o && !play_irq_clr_i && !init_clr_i |=> play_irq_o;
   endproperty
   property p_play_start;
      s_play_start |=> play_irq_o;
   endproperty
   property p_init_play;
      s_init |=> play_irq_o;
   endproperty
   property p_init_rec;
      init_clr_i && ce_i |=> !rec_irq_o;
   endproperty
   // A frozen enable must leave both irq levels and bvalid as they were
   property p_freeze;
      !ce_i |=> $stable(rec_irq_o) && $stable(play_irq_o) && $stable(s_axi_bvalid);
   endproperty
   // ----
   // Assertions
   // ----
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   a_rd_resp: assert property (p_rd_resp) else $error("read data late");
   a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
   a_b_stand: assert property (p_b_stand) else $error("write response dropped");
   a_r_stand: assert property (p_r_stand) else $error("read data dropped");
   a_rec_hold: assert property (p_rec_hold) else $error("rec irq lost");
   a_play_hold: assert property (p_play_hold) else $error("play irq lost");
   a_play_start: assert property (p_play_start) else $error("start kept count");
   a_init_play: assert property (p_init_play) else $error("clear kept count");
   a_init_rec: assert property (p_init_rec) else $error("clear kept rec irq");
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
bind msq_seq msq_seq_checker chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
   .init_clr_i(init_clr_i), .msg_valid_i(msg_valid_i), .msg_code_i(msg_code_i),
   .msg_dst_i(msg_dst_i), .rec_irq_clr_i(rec_irq_clr_i), .play_irq_clr_i(play_irq_clr_i),
   .rec_irq_o(rec_irq_o), .play_irq_o(play_irq_o), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== dv/msq_midi_src.sv
/*
 MIDI clock distributor stand-in: one-cycle pulses at a programmable spacing.
 Assumes the same system clock as the block; a new spacing applies at the next reload.
*/
`timescale 1ns/10ps
module msq_midi_src (
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [15:0] period_i, // Cycles between pulses
   output logic midi_clk_o // MIDI clock pulse
);
   logic [15:0] cnt_reg;
   // Free-running down counter, reload and pulse together
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 16'h0000;
         midi_clk_o <= 1'b0;
      end else if (cnt_reg == 16'h0000) begin
         cnt_reg <= period_i - 16'h0001;
         midi_clk_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg - 16'h0001;
         midi_clk_o <= 1'b0;
      end
   end
endmodule

// ===== dv/msq_seq_tb.sv
/*
 Self-checking bench for the sequencer counters: host bus, messages, irq clears.
 Assumes the MIDI clock stand-in and the bound checker.
*/
`timescale 1ns/10ps
`include "msq_regs.vh"
module msq_seq_tb;
   logic clock_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, init_clr_i = 1'b0, msg_valid_i = 1'b0;
   logic rec_irq_clr_i = 1'b0, play_irq_clr_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] msg_code_i = 8'h00;
   logic [1:0] msg_dst_i = 2'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [15:0] period = 16'h0080;
   wire rec_irq_o, play_irq_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire s_axi_arready, s_axi_rvalid, midi_clk;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer err_count = 0, num_checks = 0;
   // ----
   // Clock, block and MIDI clock source
   // ----
   always #50 clock_i = ~clock_i;
   msq_seq dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .init_clr_i(init_clr_i),
      .midi_clk_i(midi_clk), .msg_valid_i(msg_valid_i), .msg_code_i(msg_code_i),
      .msg_dst_i(msg_dst_i), .rec_irq_clr_i(rec_irq_clr_i), .play_irq_clr_i(play_irq_clr_i),
      .rec_irq_o(rec_irq_o), .play_irq_o(play_irq_o), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   msq_midi_src src_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .period_i(period),
      .midi_clk_o(midi_clk));
   // ----
   // Helpers
   // ----
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   // Any wait that runs out ends the run as a mismatch
   task guard(inout integer n);
      begin
         n = n + 1;
         if (n > 20000) begin
            chk_bit(1'b0, 1'b1);
            wrap_up;
         end
      end
   endtask
   task tick(input integer k);
      repeat (k) @(posedge clock_i);
   endtask
   task wait_midi(input integer k);
      integer n;
      begin
         n = 0;
         while (k > 0) begin
            @(posedge clock_i);
            if (midi_clk === 1'b1) k = k - 1;
            guard(n);
         end
      end
   endtask
   // Write: offer address and data, drop each on its take, then take the response
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      integer n;
      logic aw, w;
      begin
         n = 0;
         aw = 1'b1;
         w = 1'b1;
         @(posedge clock_i);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         while (aw || w) begin
            @(posedge clock_i);
            if (aw && s_axi_awready === 1'b1) begin
               aw = 1'b0;
               s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
               w = 1'b0;
               s_axi_wvalid <= 1'b0;
            end
            guard(n);
         end
         while (s_axi_bvalid !== 1'b1) begin
            @(posedge clock_i);
            guard(n);
         end
         s_axi_bready <= 1'b1;
         @(posedge clock_i);
         chk_word({30'h0, s_axi_bresp}, {30'h0, `MSQ_RESP_OK});
         s_axi_bready <= 1'b0;
         tick(16);
      end
   endtask
   task rd_chk(input logic [3:0] a, input logic [31:0] exp);
      integer n;
      begin
         n = 0;
         @(posedge clock_i);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do begin
            @(posedge clock_i);
            guard(n);
         end while (s_axi_arready !== 1'b1);
         s_axi_arvalid <= 1'b0;
         while (s_axi_rvalid !== 1'b1) begin
            @(posedge clock_i);
            guard(n);
         end
         s_axi_rready <= 1'b1;
         @(posedge clock_i);
         chk_word(s_axi_rdata, exp);
         chk_word({30'h0, s_axi_rresp}, {30'h0, `MSQ_RESP_OK});
         s_axi_rready <= 1'b0;
         tick(16);
      end
   endtask
   task send_msg(input logic [7:0] code, input logic [1:0] dst);
      begin
         @(posedge clock_i);
         msg_valid_i <= 1'b1;
         msg_code_i <= code;
         msg_dst_i <= dst;
         @(posedge clock_i);
         msg_valid_i <= 1'b0;
      end
   endtask
   task pulse_clr(input logic rec);
      begin
         @(posedge clock_i);
         rec_irq_clr_i <= rec;
         play_irq_clr_i <= ~rec;
         @(posedge clock_i);
         rec_irq_clr_i <= 1'b0;
         play_irq_clr_i <= 1'b0;
         tick(2);
      end
   endtask
   // Run one counted stretch of k MIDI clocks, aligned just after a MIDI clock
   task seg(input logic [7:0] code, input logic [1:0] dst, input integer k);
      begin
         wait_midi(1);
         tick(3);
         send_msg(code, dst);
         wait_midi(k);
         tick(3);
         send_msg(`MSQ_MSG_STOP, dst);
         tick(20);
      end
   endtask
   // ----
   // Scenarios
   // ----
   task t_reset;
      begin
         ce_i <= 1'b0;
         tick(5);
         ce_i <= 1'b1;
         rd_chk(`MSQ_OFS_REC_COUNT, 32'h0);
         rd_chk(`MSQ_OFS_CTRL, 32'h0);
         chk_bit(rec_irq_o, 1'b0);
         chk_bit(play_irq_o, 1'b1);
         $display("reset test done");
      end
   endtask
   // Spacing shrinks then grows; the total stays rate times MIDI clocks
   task t_interp;
      begin
         axi_wr(`MSQ_OFS_CTRL, 32'h4);
         wait_midi(3);
         tick(3);
         send_msg(`MSQ_MSG_START, 2'h1);
         wait_midi(2);
         period <= 16'h0040;
         wait_midi(2);
         period <= 16'h0100;
         wait_midi(2);
         tick(3);
         send_msg(`MSQ_MSG_STOP, 2'h1);
         tick(20);
         rd_chk(`MSQ_OFS_REC_COUNT, 32'h18);
         period <= 16'h0080;
         init_clr_i <= 1'b1;
         tick(1);
         init_clr_i <= 1'b0;
         tick(3);
         rd_chk(`MSQ_OFS_REC_COUNT, 32'h0);
         $display("interpolation test done");
      end
   endtask
   task t_wrap;
      begin
         axi_wr(`MSQ_OFS_CTRL, 32'h8);
         wait_midi(3);
         seg(`MSQ_MSG_START, 2'h1, 31);
         rd_chk(`MSQ_OFS_REC_COUNT, 32'hf8);
         seg(`MSQ_MSG_CONT, 2'h1, 1);
         rd_chk(`MSQ_OFS_REC_COUNT, 32'h0);
         chk_bit(rec_irq_o, 1'b1);
         tick(40);
         chk_bit(rec_irq_o, 1'b1);
         pulse_clr(1'b1);
         chk_bit(rec_irq_o, 1'b0);
         $display("wrap test done");
      end
   endtask
   task t_play;
      begin
         pulse_clr(1'b0);
         chk_bit(play_irq_o, 1'b1);
         axi_wr(`MSQ_OFS_ADD_LO, 32'hff);
         axi_wr(`MSQ_OFS_ADD_HI, 32'h7f);
         axi_wr(`MSQ_OFS_CTRL, 32'h34);
         pulse_clr(1'b0);
         chk_bit(play_irq_o, 1'b0);
         axi_wr(`MSQ_OFS_CTRL, 32'h14);
         chk_bit(play_irq_o, 1'b1);
         wait_midi(2);
         tick(3);
         send_msg(`MSQ_MSG_START, 2'h2);
         axi_wr(`MSQ_OFS_ADD_LO, 32'h10);
         axi_wr(`MSQ_OFS_ADD_HI, 32'h0);
         axi_wr(`MSQ_OFS_CTRL, 32'h24);
         pulse_clr(1'b0);
         chk_bit(play_irq_o, 1'b0);
         wait_midi(3);
         tick(8);
         chk_bit(play_irq_o, 1'b0);
         wait_midi(2);
         tick(8);
         chk_bit(play_irq_o, 1'b1);
         send_msg(`MSQ_MSG_STOP, 2'h2);
         rd_chk(`MSQ_OFS_REC_COUNT, 32'h0);
         $display("playback test done");
      end
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      tick(10);
      rst_n_i <= 1'b1;
      tick(2);
      t_reset;
      t_interp;
      t_wrap;
      t_play;
      wrap_up;
   end
endmodule
